/* File: core/lcig_consts.vh */
// Constants for the logic cell input gating block.
`ifndef LCIG_CONSTS_VH
`define LCIG_CONSTS_VH
// Register byte offsets on the AXI4-Lite bus.
`define LCIG_OFS_DATA1_SEL  8'h00
`define LCIG_OFS_DATA2_SEL  8'h04
`define LCIG_OFS_DATA3_SEL  8'h08
`define LCIG_OFS_DATA4_SEL  8'h0C
`define LCIG_OFS_GATE1_EN   8'h10
`define LCIG_OFS_GATE2_EN   8'h14
`define LCIG_OFS_STATUS     8'h18
// Address bits that select a word.
`define LCIG_ADDR_MSB       7
`define LCIG_ADDR_LSB       2
// Width of a source select field and of a gate enable register.
`define LCIG_SRC_W          6
`define LCIG_EN_W           8
// Number of selectable sources (six-bit code).
`define LCIG_NSRC           64
// Gate enable bit positions.
`define LCIG_IN4_TRUE       7
`define LCIG_IN4_INV        6
`define LCIG_IN3_TRUE       5
`define LCIG_IN3_INV        4
`define LCIG_IN2_TRUE       3
`define LCIG_IN2_INV        2
`define LCIG_IN1_TRUE       1
`define LCIG_IN1_INV        0
// AXI responses.
`define LCIG_RESP_OKAY      2'h0
`define LCIG_RESP_SLVERR    2'h2
`endif

/* File: core/lcig_gate.v */
// One input gate: OR of the enabled true and inverted data copies.
`timescale 1ns/100ps
`default_nettype none
`include "lcig_consts.vh"
module lcig_gate (
  // Data inputs after source selection.
  input  wire [3:0] dataIn,
  // Enable bits in the gate register layout.
  input  wire [7:0] enableBits,
  // Gate result, registered by the top level before it leaves.
  output wire       gateOut
);
  wire [7:0] terms;  // Each enabled copy, or zero when not enabled.

  // A true bit passes the data, a negated bit its inverse; both may be on.
  assign terms[`LCIG_IN4_TRUE] = enableBits[`LCIG_IN4_TRUE] & dataIn[3];
  assign terms[`LCIG_IN4_INV]  = enableBits[`LCIG_IN4_INV]  & ~dataIn[3];
  assign terms[`LCIG_IN3_TRUE] = enableBits[`LCIG_IN3_TRUE] & dataIn[2];
  assign terms[`LCIG_IN3_INV]  = enableBits[`LCIG_IN3_INV]  & ~dataIn[2];
  assign terms[`LCIG_IN2_TRUE] = enableBits[`LCIG_IN2_TRUE] & dataIn[1];
  assign terms[`LCIG_IN2_INV]  = enableBits[`LCIG_IN2_INV]  & ~dataIn[1];
  assign terms[`LCIG_IN1_TRUE] = enableBits[`LCIG_IN1_TRUE] & dataIn[0];
  assign terms[`LCIG_IN1_INV]  = enableBits[`LCIG_IN1_INV]  & ~dataIn[0];

  // No enabled input leaves the gate at zero.
  assign gateOut = |terms;
endmodule
`default_nettype wire

/* File: core/lcig_top.v */
// Logic cell input gating front end with its AXI4-Lite registers.
//
// Overview of operation
// - Data-4 select: six-bit source field, low bits.
// - Data-4 select bits 7-6 read zero.
// - Select registers read/write; kept over soft resets.
// - Gate 1 bits pair true/inverted, data 4 first.
// - Enabled bit feeds signal; cleared bit does not.
// - True bit passes data; negated passes inverse.
// - Gate 2 register has same layout as gate 1.
// - Data 1-3 have matching six-bit source fields.
`timescale 1ns/100ps
`default_nettype none
`include "lcig_consts.vh"
module lcig_top (
  // Clock and power-on reset.
  input  wire        core_clk,
  input  wire        reset,
  // AXI4-Lite write address.
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  // AXI4-Lite write data.
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  // AXI4-Lite write response.
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // AXI4-Lite read address.
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  // AXI4-Lite read data.
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Candidate sources for the four data inputs, from outside the domain.
  input  wire [63:0] sourcePins,
  // Gate outputs toward the logic function, registered.
  output reg         firstGate,
  output reg         secondGate
);
  // Select and enable registers. They take no reset at all: their value
  // is undefined at power-on and every other reset leaves them alone.
  reg [5:0]  data1SourceField_q;  // Data 1 source code.
  reg [5:0]  data2SourceField_q;  // Data 2 source code.
  reg [5:0]  data3SourceField_q;  // Data 3 source code.
  reg [5:0]  data4SourceField_q;  // Data 4 source code.
  reg [7:0]  gate1InputEnable_q;  // Gate 1 enable bits.
  reg [7:0]  gate2InputEnable_q;  // Gate 2 enable bits.

  // Write channel capture.
  reg        awHeld_q;            // Address taken, waiting for data.
  reg [7:0]  awAddr_q;            // Captured write address.
  reg        wHeld_q;             // Data taken, waiting for address.
  reg [31:0] wData_q;             // Captured write data.
  reg [3:0]  wStrb_q;             // Captured byte strobes.

  // Source synchroniser: stage one is read only by stage two.
  reg [63:0] srcMeta_q;           // First stage.
  reg [63:0] srcSync_q;           // Second stage, used by the logic.

  wire [3:0] dataSel;             // The four selected data inputs.
  wire       gate1Raw;            // Gate 1 combinational result.
  wire       gate2Raw;            // Gate 2 combinational result.
  wire       doWrite;             // Both halves of a write are held.

  // Decode a byte address to a register hit; shared by reads and writes.
  function isReg;
    input [7:0] addr;
    input [7:0] ofs;
    begin
      isReg = (addr[`LCIG_ADDR_MSB:`LCIG_ADDR_LSB] ==
               ofs[`LCIG_ADDR_MSB:`LCIG_ADDR_LSB]);
    end
  endfunction

  // Is the address one of the mapped registers.
  function isMapped;
    input [7:0] addr;
    begin
      isMapped = isReg(addr, `LCIG_OFS_DATA1_SEL) |
                 isReg(addr, `LCIG_OFS_DATA2_SEL) |
                 isReg(addr, `LCIG_OFS_DATA3_SEL) |
                 isReg(addr, `LCIG_OFS_DATA4_SEL) |
                 isReg(addr, `LCIG_OFS_GATE1_EN)  |
                 isReg(addr, `LCIG_OFS_GATE2_EN)  |
                 isReg(addr, `LCIG_OFS_STATUS);
    end
  endfunction

  // Address and data are accepted while not already held and no
  // response is pending; this keeps one write in flight.
  assign s_axi_awready = ~awHeld_q & ~s_axi_bvalid;
  assign s_axi_wready  = ~wHeld_q & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  assign doWrite       = awHeld_q & wHeld_q;

  // Capture write address and data in either order.
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      awHeld_q <= 1'b0;
      awAddr_q <= 8'h00;
      wHeld_q  <= 1'b0;
      wData_q  <= 32'h0000_0000;
      wStrb_q  <= 4'h0;
    end else begin
      if (doWrite) begin
        awHeld_q <= 1'b0;
        wHeld_q  <= 1'b0;
      end else begin
        if (s_axi_awvalid && s_axi_awready) begin
          awHeld_q <= 1'b1;
          awAddr_q <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
          wHeld_q <= 1'b1;
          wData_q <= s_axi_wdata;
          wStrb_q <= s_axi_wstrb;
        end
      end
    end
  end

  // Write response: an unmapped address answers with SLVERR.
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `LCIG_RESP_OKAY;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= isMapped(awAddr_q) ? `LCIG_RESP_OKAY
                                         : `LCIG_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Register writes. Only byte lane 0 holds data; the upper two bits of
  // each select field are not stored, so writes to them vanish.
  always @(posedge core_clk) begin
    if (doWrite && wStrb_q[0]) begin
      if (isReg(awAddr_q, `LCIG_OFS_DATA1_SEL)) begin
        data1SourceField_q <= wData_q[`LCIG_SRC_W-1:0];
      end
      if (isReg(awAddr_q, `LCIG_OFS_DATA2_SEL)) begin
        data2SourceField_q <= wData_q[`LCIG_SRC_W-1:0];
      end
      if (isReg(awAddr_q, `LCIG_OFS_DATA3_SEL)) begin
        data3SourceField_q <= wData_q[`LCIG_SRC_W-1:0];
      end
      if (isReg(awAddr_q, `LCIG_OFS_DATA4_SEL)) begin
        data4SourceField_q <= wData_q[`LCIG_SRC_W-1:0];
      end
      if (isReg(awAddr_q, `LCIG_OFS_GATE1_EN)) begin
        gate1InputEnable_q <= wData_q[`LCIG_EN_W-1:0];
      end
      if (isReg(awAddr_q, `LCIG_OFS_GATE2_EN)) begin
        gate2InputEnable_q <= wData_q[`LCIG_EN_W-1:0];
      end
    end
  end

  // Read path: one cycle after the address is taken. Unused bits are 0.
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `LCIG_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= isMapped(s_axi_araddr) ? `LCIG_RESP_OKAY
                                             : `LCIG_RESP_SLVERR;
      if (isReg(s_axi_araddr, `LCIG_OFS_DATA1_SEL)) begin
        s_axi_rdata <= {26'h0, data1SourceField_q};
      end else if (isReg(s_axi_araddr, `LCIG_OFS_DATA2_SEL)) begin
        s_axi_rdata <= {26'h0, data2SourceField_q};
      end else if (isReg(s_axi_araddr, `LCIG_OFS_DATA3_SEL)) begin
        s_axi_rdata <= {26'h0, data3SourceField_q};
      end else if (isReg(s_axi_araddr, `LCIG_OFS_DATA4_SEL)) begin
        s_axi_rdata <= {26'h0, data4SourceField_q};
      end else if (isReg(s_axi_araddr, `LCIG_OFS_GATE1_EN)) begin
        s_axi_rdata <= {24'h0, gate1InputEnable_q};
      end else if (isReg(s_axi_araddr, `LCIG_OFS_GATE2_EN)) begin
        s_axi_rdata <= {24'h0, gate2InputEnable_q};
      end else if (isReg(s_axi_araddr, `LCIG_OFS_STATUS)) begin
        // Live view of data inputs and gate outputs.
        s_axi_rdata <= {26'h0, secondGate, firstGate, dataSel};
      end else begin
        s_axi_rdata <= 32'h0000_0000;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Two-flop synchroniser on every source line.
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      srcMeta_q <= 64'h0000_0000_0000_0000;
      srcSync_q <= 64'h0000_0000_0000_0000;
    end else begin
      srcMeta_q <= sourcePins;
      srcSync_q <= srcMeta_q;
    end
  end

  // Each data input picks its own source from the common list.
  assign dataSel[0] = srcSync_q[data1SourceField_q];
  assign dataSel[1] = srcSync_q[data2SourceField_q];
  assign dataSel[2] = srcSync_q[data3SourceField_q];
  assign dataSel[3] = srcSync_q[data4SourceField_q];

  // Gate 1 and gate 2 share the same structure and layout.
  lcig_gate gate1Inst (
    .dataIn     (dataSel),
    .enableBits (gate1InputEnable_q),
    .gateOut    (gate1Raw)
  );

  lcig_gate gate2Inst (
    .dataIn     (dataSel),
    .enableBits (gate2InputEnable_q),
    .gateOut    (gate2Raw)
  );

  // Gate outputs are registered so the ports come from flip-flops.
  // Until software writes the enables their value, like the
  // registers', is undefined; reset forces the outputs low only.
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      firstGate  <= 1'b0;
      secondGate <= 1'b0;
    end else begin
      firstGate  <= gate1Raw;
      secondGate <= gate2Raw;
    end
  end
endmodule
`default_nettype wire

/* File: test/lcig_chk.sv */
// Bus and register checker for the input gating block.
`timescale 1ns/100ps
`default_nettype none
`include "lcig_consts.vh"
module lcig_chk (
  // Clock and reset.
  input wire logic        core_clk,
  input wire logic        reset,
  // Write channels.
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  // Read channels.
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  // Gate output.
  input wire logic        firstGate
);
  // Address of the read in flight, so read data can be judged by register.
  logic [7:0] rdAddr_q;
  always @(posedge core_clk) begin
    if (s_axi_arvalid && s_axi_arready) begin
      rdAddr_q <= s_axi_araddr;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("read not answered");
  a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while busy");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write not answered");
  a_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("response dropped");
  a_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write address taken while busy");
  a_sel_upper: assert property (
    s_axi_rvalid && rdAddr_q <= `LCIG_OFS_DATA4_SEL |->
    s_axi_rdata[31:6] == 26'h0 && s_axi_rresp == `LCIG_RESP_OKAY)
    else $error("select register upper bits not zero");
  a_gate_upper: assert property (
    s_axi_rvalid && (rdAddr_q == `LCIG_OFS_GATE1_EN ||
    rdAddr_q == `LCIG_OFS_GATE2_EN) |-> s_axi_rdata[31:8] == 24'h0)
    else $error("gate register upper bits not zero");
  // Judged by word index: bytes 0x19 to 0x1B still reach the status word.
  a_unmapped_read: assert property (s_axi_rvalid && rdAddr_q[7:2] > 6'h06 |->
    s_axi_rdata == 32'h0 && s_axi_rresp == `LCIG_RESP_SLVERR)
    else $error("unmapped read not refused");
  c_read: cover property (s_axi_rvalid && s_axi_rready);
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_gate: cover property ($rose(firstGate));
endmodule
bind lcig_top lcig_chk i_chk (.core_clk, .reset, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
  .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
  .s_axi_rresp, .firstGate);
`default_nettype wire

/* File: test/tb_lcig_top.sv */
// Self-checking bench for the input gating block.
`timescale 1ns/100ps
`default_nettype none
`include "lcig_consts.vh"
module tb_lcig_top;
  logic        core_clk = 1'b0;
  logic        reset = 1'b1;
  logic [7:0]  awAddr = 8'h00, arAddr = 8'h00;
  logic [31:0] wData = 32'h0;
  logic        awValid = 0, wValid = 0, bReady = 0, arValid = 0, rReady = 0;
  logic        awReady, wReady, bValid, arReady, rValid;
  logic        firstGateOut, secondGateOut;
  logic [3:0]  wStrb = 4'hF;
  logic [1:0]  bResp, rResp;
  logic [31:0] rData;
  logic [63:0] pins = 64'h0;
  logic [5:0]  srcCode [4] = '{6'h03, 6'h0A, 6'h21, 6'h3F};
  int          num_errors = 0;
  int          checks = 0;
  always #5 core_clk = ~core_clk;
  // Strobes stay on all lanes except in the lane 0 masking test.
  lcig_top i_dut (.core_clk(core_clk), .reset(reset),
    .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
    .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid),
    .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid),
    .s_axi_bready(bReady), .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
    .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
    .s_axi_rvalid(rValid), .s_axi_rready(rReady), .sourcePins(pins),
    .firstGate(firstGateOut), .secondGate(secondGateOut));
  task automatic chk(input string name, input logic [31:0] exp, got);
    checks++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", name, exp, got);
      num_errors++;
    end
  endtask
  // Each half of the write is dropped as soon as it is taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    @(posedge core_clk);
    awAddr  <= a;
    wData   <= d;
    awValid <= 1'b1;
    wValid  <= 1'b1;
    bReady  <= 1'b1;
    do begin
      @(posedge core_clk);
      if (awReady) awValid <= 1'b0;
      if (wReady) wValid <= 1'b0;
    end while (bValid !== 1'b1);
    bReady <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, bResp});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                    input logic [1:0] er);
    @(posedge core_clk);
    arAddr  <= a;
    arValid <= 1'b1;
    rReady  <= 1'b1;
    do begin
      @(posedge core_clk);
      if (arReady) arValid <= 1'b0;
    end while (rValid !== 1'b1);
    rReady <= 1'b0;
    chk("rdata", exp, rData);
    chk("rresp", {30'h0, er}, {30'h0, rResp});
  endtask
  // Reference gate: OR of the enabled true and inverted copies.
  function automatic logic gateRef(input logic [7:0] e, input logic [3:0] d);
    gateRef = 1'b0;
    for (int i = 0; i < 4; i++)
      gateRef |= (e[2*i+1] & d[i]) | (e[2*i] & ~d[i]);
  endfunction
  task automatic final_report();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #100000;
    num_errors++;
    final_report();
  end
  initial begin
    logic [7:0]  e;
    logic [63:0] p;
    logic [31:0] st;
    logic        want1, want2;
    repeat (8) @(posedge core_clk);
    reset <= 1'b0;
    // Upper select bits are written as ones and must read back zero.
    for (int i = 0; i < 4; i++) begin
      wr(8'(4*i), 32'hFFFF_FFC0 | srcCode[i], 2'h0);
      rd(8'(4*i), {26'h0, srcCode[i]}, 2'h0);
    end
    wr(`LCIG_OFS_GATE1_EN, 32'hFFFF_FF5A, 2'h0);
    wr(`LCIG_OFS_GATE2_EN, 32'h0000_00A5, 2'h0);
    rd(`LCIG_OFS_GATE1_EN, 32'h0000_005A, 2'h0);
    rd(`LCIG_OFS_GATE2_EN, 32'h0000_00A5, 2'h0);
    wr(8'h40, 32'h0000_0001, `LCIG_RESP_SLVERR);
    rd(8'h40, 32'h0, `LCIG_RESP_SLVERR);
    // Lane 0 strobe low: the write is answered but must not land.
    wStrb <= 4'hE;
    wr(`LCIG_OFS_DATA1_SEL, 32'h0000_003C, 2'h0);
    wStrb <= 4'hF;
    rd(`LCIG_OFS_DATA1_SEL, 32'h0000_0003, 2'h0);
    // Walk each enable bit, none, and both copies of data 4.
    for (int k = 0; k < 10; k++) begin
      e = (k < 8) ? 8'h01 << k : ((k == 8) ? 8'h00 : 8'hC0);
      wr(`LCIG_OFS_GATE1_EN, {24'h0, e}, 2'h0);
      wr(`LCIG_OFS_GATE2_EN, {24'h0, ~e}, 2'h0);
      for (int v = 0; v < 16; v++) begin
        // Unselected pins carry the inverted parity of the four selected levels to expose a bad mux.
        p = {64{~^v[3:0]}};
        p[3] = v[0];
        p[10] = v[1];
        p[33] = v[2];
        p[63] = v[3];
        @(posedge core_clk);
        pins <= p;
        repeat (5) @(posedge core_clk);
        want1 = gateRef(e, v[3:0]);
        want2 = gateRef(~e, v[3:0]);
        chk("firstGate", 32'(want1), 32'(firstGateOut));
        chk("secondGate", 32'(want2), 32'(secondGateOut));
      end
    end
    // Status is read-only; it shows the last step: all inputs high.
    wr(`LCIG_OFS_STATUS, 32'h0000_00FF, 2'h0);
    st = {26'h0, gateRef(~e, 4'hF), gateRef(e, 4'hF), 4'hF};
    rd(`LCIG_OFS_STATUS, st, 2'h0);
    final_report();
  end
endmodule
`default_nettype wire
